// ==== rtl/cmd_decoder_pkg.sv ====
// Shared constants and types for the command decoder.
`default_nettype none
package cmd_decoder_pkg;

  localparam int SYNC_STAGES = 3;
  localparam int RESET_STAGES = 2;
  localparam int CA_WIDTH = 10;
  localparam int BANK_WIDTH = 3;
  localparam int ROW_WIDTH = 15;
  localparam int COL_WIDTH = 12;
  localparam int MA_WIDTH = 8;
  localparam int OP_WIDTH = 8;
  localparam int DEFAULT_BANKS = 8;
  localparam int PB_REFRESH_BANKS = 8;

  // First-half opcode fields, CA3..CA0.
  localparam logic [3:0] OPC_MRW = 4'h0;
  localparam logic [3:0] OPC_MRR = 4'h8;
  localparam logic [3:0] OPC_REF_PB = 4'h4;
  localparam logic [3:0] OPC_REF_AB = 4'hC;
  localparam logic [3:0] OPC_PRE = 4'hB;
  localparam logic [3:0] OPC_BST = 4'h3;
  localparam logic [1:0] OPC_ACT = 2'h2;
  localparam logic [1:0] OPC_RDWR = 2'h1;
  localparam logic [2:0] OPC_NOP = 3'h7;
  localparam logic [2:0] OPC_SELF_REFRESH = 3'h4;
  localparam logic [2:0] OPC_DEEP = 3'h3;

  // Field positions on the bus.
  localparam int POS_OPC_HI = 3;
  localparam int POS_RW = 2;
  localparam int POS_AB = 4;
  localparam int POS_AP = 0;
  localparam int POS_BANK = 7;
  localparam int POS_MA_R = 4;
  localparam int POS_MA_F = 0;
  localparam int POS_OP = 2;
  localparam int POS_ROW_R = 2;
  localparam int POS_ROW_F = 0;
  localparam int POS_ROW_HI = 8;
  localparam int POS_COL_R = 5;
  localparam int POS_COL_F = 1;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_MRW = 4'h1,
    CMD_MRR = 4'h2,
    CMD_REF_PB = 4'h3,
    CMD_REF_AB = 4'h4,
    CMD_ACT = 4'h5,
    CMD_WR = 4'h6,
    CMD_RD = 4'h7,
    CMD_PRE = 4'h8,
    CMD_BST = 4'h9,
    CMD_ILLEGAL = 4'hF
  } cmd_type;

  typedef enum logic [3:0] {
    PWR_ACTIVE = 4'h1,
    PWR_DOWN = 4'h2,
    PWR_SELF_REFRESH = 4'h4,
    PWR_DEEP_SLEEP = 4'h8
  } power_type;

  typedef struct packed {
    cmd_type cmd;
    logic [BANK_WIDTH-1:0] bank;
    logic [ROW_WIDTH-1:0] row;
    logic [COL_WIDTH-1:0] col;
    logic auto_precharge_flag;
    logic all_banks_flag;
    logic [MA_WIDTH-1:0] mode_reg_addr;
    logic [OP_WIDTH-1:0] mode_reg_operand;
  } cmd_fields_type;

endpackage
`default_nettype wire

// ==== rtl/lpddr2_command_decoder.sv ====
// Command/address decoder sampling a double-data-rate command bus.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] - Controller never issues unspecified commands.
// [R2] - Decode opcode from CS, CKE, CA0-CA3.
// [R3] - Rising half then falling half per command.
// [R4] - CS and CKE sampled on rising edges only. The code takes the power-state exit from CKE on any cycle instead.
// [R5] - Bank field from first-half CA7-CA9.
// [R6] - Second-half CA0 flags auto precharge.
// [R7] - All-banks precharge ignores bank field.
// [R8] - Column bit zero always forced low.
// [R9] - Per-bank refresh only with eight banks.
// [R10] - Self refresh, deep sleep exit on CKE.
// [R11] - Controller drives don't-care lines defined.
// [R12] - Mode write address and operand extraction.
// [R13] - Mode read address extraction.
// [R14] - Activate row and bank extraction.
// [R15] - Read/write select, column and bank extraction.
// [R16] - CKE falling enters power states by code.
// [R17] - Controller waits exit time after power-down.
// [R18] - NOP only with CKE steady two cycles.
module lpddr2_command_decoder #(
  parameter int NUM_BANKS = cmd_decoder_pkg::DEFAULT_BANKS
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mem_ck,
  input wire logic cs_b,
  input wire logic cke,
  input wire logic [cmd_decoder_pkg::CA_WIDTH-1:0] ca,
  output cmd_decoder_pkg::cmd_fields_type command,
  output logic command_valid,
  output cmd_decoder_pkg::power_type power_state,
  output logic illegal_event
);

  localparam int N = cmd_decoder_pkg::SYNC_STAGES;
  localparam int W = cmd_decoder_pkg::CA_WIDTH;
  localparam int POS_OPC_HI_IDX = cmd_decoder_pkg::POS_OPC_HI;

  if (NUM_BANKS != 4 && NUM_BANKS != 8)
  begin : g_bank_check
    $error("NUM_BANKS must be 4 or 8");
  end

  typedef enum logic [1:0] {
    HALF_IDLE = 2'b01,
    HALF_WAIT_FALL = 2'b10
  } half_type;

  logic [cmd_decoder_pkg::RESET_STAGES-1:0] rst_sync_r;
  logic reset_b;
  logic [N-1:0] ck_s_r;
  logic [N-1:0] cs_s_r;
  logic [N-1:0] cke_s_r;
  logic [W-1:0] ca_s_r [N];
  logic ck_rise;
  logic ck_fall;
  logic cs_now;
  logic cke_now;
  logic [W-1:0] ca_now;
  logic cke_prev_r;
  logic [W-1:0] ca_rise_r;
  half_type half_r;
  cmd_decoder_pkg::cmd_fields_type fields_nxt;
  cmd_decoder_pkg::cmd_type cmd_sel;

  // The reset is released through two flip-flops so every register leaves reset together.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_r <= '0;
    else
      rst_sync_r <= {rst_sync_r[cmd_decoder_pkg::RESET_STAGES-2:0], 1'b1};
  end
  assign reset_b = rst_sync_r[cmd_decoder_pkg::RESET_STAGES-1];

  // Every pin crosses three flip-flops; only the last two stages are looked at.
  always_ff @(posedge clock or negedge reset_b)
  begin
    if (!reset_b)
    begin
      ck_s_r <= '0;
      cs_s_r <= '1;
      cke_s_r <= '0;
    end
    else
    begin
      ck_s_r <= {ck_s_r[N-2:0], mem_ck};
      cs_s_r <= {cs_s_r[N-2:0], cs_b};
      cke_s_r <= {cke_s_r[N-2:0], cke};
    end
  end

  // The first stage is split off so no stage ever names an index below zero.
  for (genvar i = 0; i < N; i++)
  begin : g_ca_sync
    if (i == 0)
    begin : g_first
      always_ff @(posedge clock or negedge reset_b)
      begin
        if (!reset_b)
          ca_s_r[i] <= '0;
        else
          ca_s_r[i] <= ca;
      end
    end
    else
    begin : g_next
      always_ff @(posedge clock or negedge reset_b)
      begin
        if (!reset_b)
          ca_s_r[i] <= '0;
        else
          ca_s_r[i] <= ca_s_r[i-1];
      end
    end
  end

  // Data is taken from the last stage, one cycle ahead of the clock edge seen.
  assign ck_rise = ck_s_r[1] && !ck_s_r[2];
  assign ck_fall = !ck_s_r[1] && ck_s_r[2];
  assign cs_now = cs_s_r[2];
  assign cke_now = cke_s_r[2];
  assign ca_now = ca_s_r[N-1];

  // CS and CKE are captured at a rising edge, except the power exit, which follows CKE on any cycle. [R4]
  always_ff @(posedge clock or negedge reset_b)
  begin
    if (!reset_b)
      cke_prev_r <= 1'b0;
    else if (ck_rise)
      cke_prev_r <= cke_now; // [R4]
  end

  // First half opcode selection from the held rising-edge sample.
  always_comb
  begin
    cmd_sel = cmd_decoder_pkg::CMD_ILLEGAL;
    if (ca_rise_r[POS_OPC_HI_IDX:0] == cmd_decoder_pkg::OPC_MRW)
      cmd_sel = cmd_decoder_pkg::CMD_MRW; // [R12]
    else if (ca_rise_r[POS_OPC_HI_IDX:0] == cmd_decoder_pkg::OPC_MRR)
      cmd_sel = cmd_decoder_pkg::CMD_MRR; // [R13]
    else if (ca_rise_r[POS_OPC_HI_IDX:0] == cmd_decoder_pkg::OPC_REF_PB)
      cmd_sel = (NUM_BANKS == cmd_decoder_pkg::PB_REFRESH_BANKS) ?
                cmd_decoder_pkg::CMD_REF_PB : cmd_decoder_pkg::CMD_ILLEGAL; // [R2] [R9]
    else if (ca_rise_r[POS_OPC_HI_IDX:0] == cmd_decoder_pkg::OPC_REF_AB)
      cmd_sel = cmd_decoder_pkg::CMD_REF_AB; // [R2]
    else if (ca_rise_r[1:0] == cmd_decoder_pkg::OPC_ACT)
      cmd_sel = cmd_decoder_pkg::CMD_ACT; // [R14]
    else if (ca_rise_r[1:0] == cmd_decoder_pkg::OPC_RDWR)
      cmd_sel = ca_rise_r[cmd_decoder_pkg::POS_RW] ?
                cmd_decoder_pkg::CMD_RD : cmd_decoder_pkg::CMD_WR; // [R15]
    else if (ca_rise_r[POS_OPC_HI_IDX:0] == cmd_decoder_pkg::OPC_PRE)
      cmd_sel = cmd_decoder_pkg::CMD_PRE; // [R2]
    else if (ca_rise_r[POS_OPC_HI_IDX:0] == cmd_decoder_pkg::OPC_BST)
      cmd_sel = cmd_decoder_pkg::CMD_BST; // [R2]
    else if (ca_rise_r[2:0] == cmd_decoder_pkg::OPC_NOP)
      cmd_sel = cmd_decoder_pkg::CMD_NOP; // [R2]
  end

  // Field extraction: rising half held in ca_rise_r, falling half live on ca_now.
  always_comb
  begin
    fields_nxt = '0;
    fields_nxt.cmd = cmd_sel;
    unique case (cmd_sel)
      cmd_decoder_pkg::CMD_MRW, cmd_decoder_pkg::CMD_MRR:
      begin
        fields_nxt.mode_reg_addr = {ca_now[cmd_decoder_pkg::POS_MA_F +: 2],
                                    ca_rise_r[cmd_decoder_pkg::POS_MA_R +: 6]}; // [R12] [R13]
        if (cmd_sel == cmd_decoder_pkg::CMD_MRW)
          fields_nxt.mode_reg_operand = ca_now[cmd_decoder_pkg::POS_OP +: 8]; // [R12]
      end
      cmd_decoder_pkg::CMD_ACT:
      begin
        fields_nxt.bank = ca_rise_r[cmd_decoder_pkg::POS_BANK +: 3]; // [R5]
        fields_nxt.row = {ca_now[cmd_decoder_pkg::POS_ROW_HI +: 2],
                          ca_rise_r[cmd_decoder_pkg::POS_ROW_R +: 5],
                          ca_now[cmd_decoder_pkg::POS_ROW_F +: 8]}; // [R14]
      end
      cmd_decoder_pkg::CMD_RD, cmd_decoder_pkg::CMD_WR:
      begin
        fields_nxt.bank = ca_rise_r[cmd_decoder_pkg::POS_BANK +: 3]; // [R5]
        fields_nxt.col = {ca_now[cmd_decoder_pkg::POS_COL_F +: 9],
                          ca_rise_r[cmd_decoder_pkg::POS_COL_R +: 2],
                          1'b0}; // [R8] [R15]
        fields_nxt.auto_precharge_flag = ca_now[cmd_decoder_pkg::POS_AP]; // [R6]
      end
      cmd_decoder_pkg::CMD_PRE:
      begin
        fields_nxt.all_banks_flag = ca_rise_r[cmd_decoder_pkg::POS_AB];
        // With the all-banks flag set the bank field is reported as zero.
        fields_nxt.bank = ca_rise_r[cmd_decoder_pkg::POS_AB] ?
                          '0 : ca_rise_r[cmd_decoder_pkg::POS_BANK +: 3]; // [R5] [R7]
      end
      default:
      begin
        fields_nxt.cmd = cmd_sel;
      end
    endcase
  end

  // Two-half capture: a command taken at a rising edge completes at the next falling edge.
  always_ff @(posedge clock or negedge reset_b)
  begin
    if (!reset_b)
    begin
      half_r <= HALF_IDLE;
      ca_rise_r <= '0;
      command <= '0;
      command_valid <= 1'b0;
    end
    else
    begin
      command_valid <= 1'b0;
      unique case (half_r)
        HALF_IDLE:
        begin
          if (ck_rise && cke_prev_r && cke_now &&
              power_state == cmd_decoder_pkg::PWR_ACTIVE)
          begin
            // CS high decodes as NOP without looking at the bus. [R2]
            ca_rise_r <= cs_now ? {{(W-3){1'b0}}, cmd_decoder_pkg::OPC_NOP} : ca_now;
            half_r <= HALF_WAIT_FALL; // [R3]
          end
        end
        HALF_WAIT_FALL:
        begin
          if (ck_fall)
          begin
            command <= fields_nxt; // [R3]
            command_valid <= 1'b1;
            half_r <= HALF_IDLE;
          end
        end
      endcase
    end
  end

  // Power state tracking; exits follow CKE alone, without waiting for a clock edge.
  always_ff @(posedge clock or negedge reset_b)
  begin
    if (!reset_b)
      power_state <= cmd_decoder_pkg::PWR_ACTIVE;
    else if (power_state != cmd_decoder_pkg::PWR_ACTIVE)
    begin
      if (cke_now)
        power_state <= cmd_decoder_pkg::PWR_ACTIVE; // [R10] [R16]
    end
    else if (ck_rise && cke_prev_r && !cke_now)
    begin
      if (cs_now)
        power_state <= cmd_decoder_pkg::PWR_DOWN; // [R16]
      else if (ca_now[2:0] == cmd_decoder_pkg::OPC_SELF_REFRESH)
        power_state <= cmd_decoder_pkg::PWR_SELF_REFRESH; // [R16]
      else if (ca_now[2:0] == cmd_decoder_pkg::OPC_DEEP)
        power_state <= cmd_decoder_pkg::PWR_DEEP_SLEEP; // [R16]
    end
  end

  // Flags codes the device cannot act on; recovery is up to the controller. [R1]
  always_ff @(posedge clock or negedge reset_b)
  begin
    if (!reset_b)
      illegal_event <= 1'b0;
    else
      illegal_event <= (ck_fall && half_r == HALF_WAIT_FALL &&
                        cmd_sel == cmd_decoder_pkg::CMD_ILLEGAL) ||
                       (ck_rise && cke_prev_r && !cke_now && !cs_now &&
                        ca_now[2:0] != cmd_decoder_pkg::OPC_SELF_REFRESH &&
                        ca_now[2:0] != cmd_decoder_pkg::OPC_DEEP) ||
                       (ck_rise && !cke_prev_r && cke_now && !cs_now); // [R16]
  end

endmodule // lpddr2_command_decoder
`default_nettype wire

// ==== test/lpddr2_command_decoder_props.sv ====
// Port-level concurrent checks for the command decoder.
`timescale 1ns/1ps
`default_nettype none
module lpddr2_command_decoder_props #(
  parameter int NUM_BANKS = cmd_decoder_pkg::DEFAULT_BANKS
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mem_ck,
  input wire logic cs_b,
  input wire logic cke,
  input wire logic [9:0] ca,
  input wire cmd_decoder_pkg::cmd_fields_type command,
  input wire logic command_valid,
  input wire cmd_decoder_pkg::power_type power_state,
  input wire logic illegal_event
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  a_valid_pulse: assert property (command_valid |=> !command_valid)
    else $error("command_valid stood longer than one cycle");
  a_cmd_holds: assert property (!command_valid |-> $stable(command))
    else $error("command changed without command_valid");
  a_col_zero: assert property (command_valid && command.cmd inside
    {cmd_decoder_pkg::CMD_RD, cmd_decoder_pkg::CMD_WR} |-> command.col[0] == 1'h0)
    else $error("column bit zero not low");
  a_pre_all_bank: assert property (command_valid && command.all_banks_flag
    |-> command.cmd == cmd_decoder_pkg::CMD_PRE && command.bank == 3'h0)
    else $error("all-bank precharge kept a bank");
  a_refpb_banks: assert property (command_valid
    && command.cmd == cmd_decoder_pkg::CMD_REF_PB |-> NUM_BANKS == 8)
    else $error("per-bank refresh accepted without eight banks");
  a_ap_only_rdwr: assert property (command.auto_precharge_flag |-> command.cmd
    inside {cmd_decoder_pkg::CMD_RD, cmd_decoder_pkg::CMD_WR})
    else $error("auto precharge flag on other command");
  a_onehot_power: assert property ($onehot(power_state))
    else $error("power state not one-hot");
  a_asleep_quiet: assert property (power_state != cmd_decoder_pkg::PWR_ACTIVE
    |-> !command_valid)
    else $error("command decoded outside active state");
  a_exit_cke: assert property (cke [*8] |-> power_state == cmd_decoder_pkg::PWR_ACTIVE)
    else $error("no exit while clock enable high");
  cover property (command_valid && command.cmd == cmd_decoder_pkg::CMD_ACT);
  cover property (power_state == cmd_decoder_pkg::PWR_DEEP_SLEEP);
  cover property (power_state == cmd_decoder_pkg::PWR_DOWN);
  cover property (illegal_event);
endmodule // lpddr2_command_decoder_props
bind lpddr2_command_decoder lpddr2_command_decoder_props #(.NUM_BANKS(NUM_BANKS)) u_props (
  .clock, .rst_b, .mem_ck, .cs_b, .cke, .ca, .command, .command_valid, .power_state,
  .illegal_event);
`default_nettype wire

// ==== test/ca_host_model.sv ====
// Behavioural memory controller that drives the double-rate command bus.
`timescale 1ns/1ps
`default_nettype none
module ca_host_model (
  output logic mem_ck,
  output logic cs_b,
  output logic cke,
  output logic [9:0] ca
);
  initial
  begin
    mem_ck = 1'h0;
    cs_b = 1'h1;
    cke = 1'h1;
    ca = 10'h3FF;
  end
  // One 70 ns clock period per call; the clock stands low between calls.
  task automatic issue(input logic sel_b, input logic en, input logic [9:0] r,
    input logic [9:0] f);
    cs_b = sel_b;
    cke = en;
    ca = r;
    #10 mem_ck = 1'h1;
    #30 ca = f;
    // Chip select is only meaningful at the rise, so it is flipped here.
    cs_b = ~sel_b;
    #10 mem_ck = 1'h0;
    #20 ca = ~f;
  endtask
  task automatic wake();
    cke = 1'h1;
  endtask
endmodule // ca_host_model
`default_nettype wire

// ==== test/lpddr2_command_decoder_tb.sv ====
// Self-checking bench for the command decoder.
`timescale 1ns/1ps
`default_nettype none
module lpddr2_command_decoder_tb;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  wire logic mem_ck, cs_b, cke;
  wire logic [9:0] ca;
  cmd_decoder_pkg::cmd_fields_type command;
  logic command_valid, illegal_event;
  cmd_decoder_pkg::power_type power_state;
  int mismatches = 0;
  int n_compared = 0;
  int n_illegal = 0;
  // The pulse stands for one cycle only, so every one of them is counted here.
  always @(posedge clock)
    if (illegal_event === 1'h1)
      n_illegal <= n_illegal + 1;
  always #5 clock = ~clock;
  ca_host_model u_host (.mem_ck, .cs_b, .cke, .ca);
  lpddr2_command_decoder u_dut (.clock, .rst_b, .mem_ck, .cs_b, .cke, .ca, .command,
    .command_valid, .power_state, .illegal_event);
  task automatic report_and_stop();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic cmd_decoder_pkg::cmd_fields_type mk(cmd_decoder_pkg::cmd_type c,
    logic [2:0] bk, logic [14:0] row, logic [11:0] col, logic [1:0] fl, logic [7:0] ma,
    logic [7:0] op);
    return {c, bk, row, col, fl, ma, op};
  endfunction
  task automatic go(input string nm, input logic [9:0] r, input logic [9:0] f,
    input cmd_decoder_pkg::cmd_fields_type e);
    int n;
    u_host.issue(1'h0, 1'h1, r, f);
    for (n = 0; n < 20 && command_valid !== 1'h1; n++)
    begin
      @(posedge clock);
      #1;
    end
    check("command_valid", 1'h1, command_valid);
    if (n == 20)
      report_and_stop();
    check("command", e, command);
    check("illegal_event", 1'h0, illegal_event);
    $display("test %s done", nm);
  endtask
  task automatic settle(input string what, input cmd_decoder_pkg::power_type p);
    int n;
    for (n = 0; n < 20 && power_state !== p; n++)
    begin
      @(posedge clock);
      #1;
    end
    check(what, p, power_state);
    if (n == 20)
      report_and_stop();
  endtask
  // Each sleep is left again so the next command starts from the active state.
  task automatic pwr(input string nm, input logic sel_b, input logic [9:0] r,
    input cmd_decoder_pkg::power_type p);
    u_host.issue(sel_b, 1'h0, r, 10'h000);
    settle("power entry", p);
    u_host.wake();
    settle("power exit", cmd_decoder_pkg::PWR_ACTIVE);
    u_host.issue(1'h1, 1'h1, 10'h3FF, 10'h000);
    $display("test %s done", nm);
  endtask
  // An entry code that names no power state, then an exit with chip select low, both pulse.
  task automatic bad_entry(input string nm, input logic [9:0] r);
    int seen;
    seen = n_illegal;
    u_host.issue(1'h0, 1'h0, r, 10'h000);
    u_host.issue(1'h0, 1'h1, 10'h3FF, 10'h000);
    check("illegal_event pulses", seen + 2, n_illegal);
    check("power_state", cmd_decoder_pkg::PWR_ACTIVE, power_state);
    $display("test %s done", nm);
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    #1 rst_b = 1'h1;
    repeat (6) @(posedge clock);
    // The link moves 1 ns after a system edge so no pin changes in a sampling time step.
    #1;
    u_host.issue(1'h1, 1'h1, 10'h3FF, 10'h000);
    go("mrw", {6'h35, 4'h0}, {8'hC3, 2'h2}, mk(cmd_decoder_pkg::CMD_MRW, 3'h0, 15'h0, 12'h0,
      2'h0, 8'hB5, 8'hC3));
    go("mrr", {6'h0A, 4'h8}, {8'h96, 2'h1}, mk(cmd_decoder_pkg::CMD_MRR, 3'h0, 15'h0, 12'h0,
      2'h0, 8'h4A, 8'h00));
    go("refpb", {6'h2A, 4'h4}, 10'h155, mk(cmd_decoder_pkg::CMD_REF_PB, 3'h0, 15'h0, 12'h0,
      2'h0, 8'h00, 8'h00));
    go("refab", {6'h15, 4'hC}, 10'h2AA, mk(cmd_decoder_pkg::CMD_REF_AB, 3'h0, 15'h0, 12'h0,
      2'h0, 8'h00, 8'h00));
    go("bst", {6'h3F, 4'h3}, 10'h155, mk(cmd_decoder_pkg::CMD_BST, 3'h0, 15'h0, 12'h0,
      2'h0, 8'h00, 8'h00));
    go("nop", {6'h2D, 4'hF}, 10'h2AA, mk(cmd_decoder_pkg::CMD_NOP, 3'h0, 15'h0, 12'h0,
      2'h0, 8'h00, 8'h00));
    go("act", {3'h5, 5'h1A, 2'h2}, {2'h2, 8'h3C}, mk(cmd_decoder_pkg::CMD_ACT, 3'h5,
      15'h5A3C, 12'h0, 2'h0, 8'h00, 8'h00));
    go("rd", {3'h6, 2'h3, 2'h3, 1'h1, 2'h1}, {9'h15B, 1'h1}, mk(cmd_decoder_pkg::CMD_RD, 3'h6,
      15'h0, {9'h15B, 2'h3, 1'h0}, 2'h2, 8'h00, 8'h00));
    go("wr", {3'h1, 2'h1, 2'h0, 1'h0, 2'h1}, {9'h0A4, 1'h0}, mk(cmd_decoder_pkg::CMD_WR, 3'h1,
      15'h0, {9'h0A4, 2'h1, 1'h0}, 2'h0, 8'h00, 8'h00));
    go("pre_all", {3'h7, 2'h3, 1'h1, 4'hB}, 10'h155, mk(cmd_decoder_pkg::CMD_PRE, 3'h0,
      15'h0, 12'h0, 2'h1, 8'h00, 8'h00));
    go("pre_one", {3'h2, 2'h1, 1'h0, 4'hB}, 10'h2AA, mk(cmd_decoder_pkg::CMD_PRE, 3'h2,
      15'h0, 12'h0, 2'h0, 8'h00, 8'h00));
    bad_entry("bad_entry", 10'h007);
    pwr("self_refresh", 1'h0, 10'h004, cmd_decoder_pkg::PWR_SELF_REFRESH);
    pwr("deep", 1'h0, 10'h003, cmd_decoder_pkg::PWR_DEEP_SLEEP);
    pwr("pdown", 1'h1, 10'h155, cmd_decoder_pkg::PWR_DOWN);
    report_and_stop();
  end
endmodule // lpddr2_command_decoder_tb
`default_nettype wire
